/* File: common/asc_defines.svh */
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
// ==========================================================================
// register byte offsets (apb, one aligned word each)
`define ASC_OFF_CTRL      12'h000
`define ASC_OFF_FORMAT    12'h004
`define ASC_OFF_PTRS      12'h008
`define ASC_OFF_COUNT     12'h00c
`define ASC_OFF_TIPHASE   12'h010
`define ASC_OFF_TPERIOD   12'h014
`define ASC_OFF_START     12'h018
`define ASC_OFF_STATUS    12'h01c
`define ASC_OFF_VCFG0     12'h020
`define ASC_OFF_VCFG1     12'h024
`define ASC_OFF_RES0      12'h040
`define ASC_OFF_RES1      12'h044
`define ASC_OFF_FLOAT     12'h080
// ==========================================================================
// group control field positions
`define ASC_CTRL_TRIG_SEL 1
`define ASC_CTRL_END_IRQ  4
`define ASC_CTRL_SCAN_MODE_FIELD   5
`define ASC_CTRL_SW_EN    6
// format control: addition count code in bits 1:0 (0 none, 1 four)
`define ASC_FMT_ADD_LSB   0
// ==========================================================================
// timer unit 25 ns against a 10 ns clock: ticks come from a nanosecond carry
`define ASC_TICK_NS       25
`define ASC_CLK_NS        10
// conversion time of the stand-in converter, cycles
`define ASC_CONV_CYC      8'h10
// reset values
`define ASC_RST_CTRL      8'h00
`define ASC_RST_PERIOD    16'h0fa0
`define ASC_VCHANS        2
`define ASC_FIFO_DEPTH    32
`endif

/* File: common/asc_pkg.sv */
package asc_pkg;
    // scan sequencer states, one-hot
    typedef enum logic [3:0] {
        ASC_IDLE = 4'b0001,
        ASC_CONV = 4'b0010,
        ASC_NEXT = 4'b0100,
        ASC_DONE = 4'b1000
    } asc_state_t;
    typedef logic [31:0] asc_word_t;
endpackage

/* File: hdl/asc_fifo.sv */
`timescale 1ns/100ps
// ==========================================================================
// result fifo: flop storage, valid/ready on both sides
module asc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];   // storage
    logic [AW-1:0]    wr_ptr;        // write index
    logic [AW-1:0]    rd_ptr;        // read index
    logic [AW:0]      fill;          // word count
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // room while the count is below depth; an empty fifo must accept
    assign in_ready  = (fill < (AW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign out_data  = mem[rd_ptr];

    // pointers and count; fill tracks both sides at once
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: hdl/asc_core.sv */
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "asc_defines.svh"
// Summary of operation
// RL1: timer expiry restarts group every period
// RL2: timer counts in 25 ns units
// RL3: load phase, count down, reload period
// RL4: group three end event requests dma
// RL5: end irq pulses once per group scan
// RL6: float window returns converted result
// RL7: dma reads fixed float port 256 times
// RL8: dma handler clears and re-arms channel
// RL9: addition mode converts channel repeatedly, sums
// RL10: format control selects addition count
// RL11: scan count zero runs once then stops
// RL12: channels scanned from start to end pointer
// RL13: control selects timer or software start
// RL14: software start launches; irq after additions
// RL15: channel config selects physical channel
// RL16: each conversion overwrites channel result
// RL17: sum result wide enough, fourteen bits
module asc_core (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire asc_pkg::asc_word_t pwdata,
    output asc_pkg::asc_word_t    prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [11:0]      conv_sample,
    output logic [3:0]            conv_channel,
    output logic                  group_three_scan_end_irq,
    output logic                  group_three_end_output,
    output asc_pkg::asc_word_t    float_result_port,
    output logic                  float_valid,
    input  wire logic             float_ready
);
    import asc_pkg::*;

    // ======================================================================
    // functions
    // signed integer to ieee single, zero maps to zero
    function automatic logic [31:0] to_float(input logic [13:0] v);
        logic [13:0] mag;
        logic [4:0]  msb;
        logic [31:0] res;
        mag = v[13] ? 14'(-v) : v;
        msb = 5'h00;
        for (int i = 0; i < 14; i++) begin
            if (mag[i]) msb = 5'(i);
        end
        res = {v[13], 8'(8'h7f + msb), 23'((32'(mag) << (23 - msb)))};
        if (mag == 14'h0000) res = 32'h0000_0000;
        return res;
    endfunction

    // ======================================================================
    // registers
    logic [7:0]  group_three_control;        // group control
    logic [7:0]  format_and_addition_ctrl;   // format/addition
    logic [15:0] group_pointers;             // end in 15:8, start in 7:0
    logic [7:0]  group_three_scan_count;     // extra scans
    logic [15:0] timer_initial_phase;        // 25 ns units
    logic [15:0] timer_period;               // 25 ns units
    logic [31:0] vchan_config [`ASC_VCHANS]; // per-channel config
    logic [13:0] vchan_result [`ASC_VCHANS]; // sum-wide results
    logic        timer_run;                  // timer started
    asc_state_t  state;
    asc_state_t  next_state;

    // ======================================================================
    // apb decode: zero-wait, pslverr above ASC_OFF_VCFG1 except the result and float offsets
    wire         acc      = psel && penable;
    wire         wr       = acc && pwrite;
    wire         rd_float = acc && !pwrite && paddr == `ASC_OFF_FLOAT;
    wire         hit_cfg  = paddr <= `ASC_OFF_VCFG1 || paddr == `ASC_OFF_RES0
                            || paddr == `ASC_OFF_RES1 || paddr == `ASC_OFF_FLOAT;
    wire         ctl_timer = group_three_control[`ASC_CTRL_TRIG_SEL];       // RL13
    wire         ctl_sw    = group_three_control[`ASC_CTRL_SW_EN];          // RL13
    wire         ctl_irq   = group_three_control[`ASC_CTRL_END_IRQ];
    wire  [1:0]  add_code  = format_and_addition_ctrl[`ASC_FMT_ADD_LSB +: 2];
    wire  [2:0]  add_total = (add_code == 2'h1) ? 3'h4 : 3'h1;             // RL10
    wire  [7:0]  ptr_start = group_pointers[7:0];
    wire  [7:0]  ptr_end   = group_pointers[15:8];
    assign pready  = 1'b1;
    assign pslverr = acc && !hit_cfg;

    // read mux
    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            `ASC_OFF_CTRL:    prdata = {24'h0, group_three_control};
            `ASC_OFF_FORMAT:  prdata = {24'h0, format_and_addition_ctrl};
            `ASC_OFF_PTRS:    prdata = {16'h0, group_pointers};
            `ASC_OFF_COUNT:   prdata = {24'h0, group_three_scan_count};
            `ASC_OFF_TIPHASE: prdata = {16'h0, timer_initial_phase};
            `ASC_OFF_TPERIOD: prdata = {16'h0, timer_period};
            `ASC_OFF_STATUS:  prdata = {28'h0, state};
            `ASC_OFF_VCFG0:   prdata = vchan_config[0];
            `ASC_OFF_VCFG1:   prdata = vchan_config[1];
            `ASC_OFF_RES0:    prdata = {18'h0, vchan_result[0]};
            `ASC_OFF_RES1:    prdata = {18'h0, vchan_result[1]};
            `ASC_OFF_FLOAT:   prdata = to_float(vchan_result[0]);      // RL6
            default:          prdata = 32'h0000_0000;
        endcase
    end

    // register writes; start register bit 0 = sw start, bit 1 = timer run
    wire sw_start = wr && paddr == `ASC_OFF_START && pwdata[0] && ctl_sw;   // RL14
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            group_three_control      <= `ASC_RST_CTRL;
            format_and_addition_ctrl <= 8'h00;
            group_pointers           <= 16'h0000;
            group_three_scan_count   <= 8'h00;
            timer_initial_phase      <= 16'h0001;
            timer_period             <= `ASC_RST_PERIOD;
            timer_run                <= 1'b0;
            vchan_config[0]          <= 32'h0000_0000;
            vchan_config[1]          <= 32'h0000_0000;
        end else if (wr) begin
            case (paddr)
                `ASC_OFF_CTRL:    group_three_control      <= pwdata[7:0];
                `ASC_OFF_FORMAT:  format_and_addition_ctrl <= pwdata[7:0];
                `ASC_OFF_PTRS:    group_pointers           <= pwdata[15:0];
                `ASC_OFF_COUNT:   group_three_scan_count   <= pwdata[7:0];
                `ASC_OFF_TIPHASE: timer_initial_phase      <= pwdata[15:0];
                `ASC_OFF_TPERIOD: timer_period             <= pwdata[15:0];
                `ASC_OFF_START:   timer_run                <= pwdata[1];
                `ASC_OFF_VCFG0:   vchan_config[0]          <= pwdata;
                `ASC_OFF_VCFG1:   vchan_config[1]          <= pwdata;
                default:          timer_run                <= timer_run;
            endcase
        end
    end

    // ======================================================================
    // interval timer: 25 ns tick from a fractional divider, down counter of ticks
    // 25 ns is not a whole number of clocks, so ticks alternate 3 and 2 cycles
    // apart; the carry keeps the average exact, so long periods do not drift
    logic [5:0]  tick_ns;      // nanoseconds carried toward the next tick
    logic [15:0] tmr_cnt;      // remaining ticks
    logic        tmr_armed;    // phase loaded
    logic        tmr_trig;     // one-cycle expiry
    wire  [5:0]  ns_sum = tick_ns + 6'(`ASC_CLK_NS);
    wire         tick   = ns_sum >= 6'(`ASC_TICK_NS);                       // RL2
    always_ff @(posedge ref_clk) begin
        if (rst || !timer_run || !ctl_timer) begin
            tick_ns   <= 6'h00;
            tmr_cnt   <= 16'h0000;
            tmr_armed <= 1'b0;
            tmr_trig  <= 1'b0;
        end else begin
            tick_ns <= tick ? ns_sum - 6'(`ASC_TICK_NS) : ns_sum;           // RL2
            tmr_trig <= 1'b0;
            if (!tmr_armed) begin
                tmr_cnt   <= timer_initial_phase;                          // RL3
                tmr_armed <= 1'b1;
            end else if (tick) begin
                if (tmr_cnt <= 16'h0001) begin
                    tmr_cnt  <= timer_period;                              // RL3
                    tmr_trig <= 1'b1;                                      // RL1
                end else begin
                    tmr_cnt <= tmr_cnt - 16'h0001;
                end
            end
        end
    end

    // ======================================================================
    // scan sequencer
    logic [7:0]  vch;          // current virtual channel
    logic [2:0]  add_done;     // conversions summed so far
    logic [7:0]  scans_done;   // completed scans
    logic [7:0]  conv_cnt;     // conversion timer
    logic [13:0] acc_sum;      // running sum
    wire         start_req = sw_start || (tmr_trig && ctl_timer);          // RL13
    wire         conv_end  = state == ASC_CONV && conv_cnt == `ASC_CONV_CYC;
    wire         last_add  = add_done + 3'h1 == add_total;
    wire         last_vch  = vch >= ptr_end;
    wire         last_scan = scans_done >= group_three_scan_count;          // RL11
    wire  [13:0] sample_x  = {{2{conv_sample[11]}}, conv_sample};          // RL17
    wire  [0:0]  vsel      = vch[0];
    assign conv_channel = vchan_config[vsel][3:0];                         // RL15

    always_comb begin
        next_state = state;
        case (state)
            ASC_IDLE: next_state = start_req ? ASC_CONV : ASC_IDLE;
            ASC_CONV: next_state = (conv_end && last_add) ? ASC_NEXT : ASC_CONV;
            ASC_NEXT: next_state = (last_vch && last_scan) ? ASC_DONE : ASC_CONV;
            ASC_DONE: next_state = ASC_IDLE;
            default:  next_state = ASC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state      <= ASC_IDLE;
            vch        <= 8'h00;
            add_done   <= 3'h0;
            scans_done <= 8'h00;
            conv_cnt   <= 8'h00;
            acc_sum    <= 14'h0000;
        end else begin
            state <= next_state;
            case (state)
                ASC_IDLE: begin
                    vch        <= ptr_start;                              // RL12
                    scans_done <= 8'h00;
                    add_done   <= 3'h0;
                    conv_cnt   <= 8'h00;
                    acc_sum    <= 14'h0000;
                end
                ASC_CONV: begin
                    conv_cnt <= conv_end ? 8'h00 : conv_cnt + 8'h01;
                    if (conv_end) begin
                        acc_sum  <= last_add ? 14'h0000 : acc_sum + sample_x; // RL9
                        add_done <= last_add ? 3'h0 : add_done + 3'h1;
                    end
                end
                ASC_NEXT: begin
                    if (last_vch) begin
                        vch        <= ptr_start;
                        scans_done <= scans_done + 8'h01;
                    end else begin
                        vch <= vch + 8'h01;                               // RL12
                    end
                end
                default: vch <= vch;
            endcase
        end
    end

    // results overwritten on every channel completion
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            vchan_result[0] <= 14'h0000;
            vchan_result[1] <= 14'h0000;
        end else if (conv_end && last_add) begin
            vchan_result[vsel] <= acc_sum + sample_x;                       // RL16
        end
    end

    // end event pulses: group end, one per completed group scan
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            group_three_scan_end_irq <= 1'b0;
            group_three_end_output   <= 1'b0;
        end else begin
            group_three_scan_end_irq <= state == ASC_DONE && ctl_irq;       // RL5 RL14
            group_three_end_output   <= state == ASC_DONE;                 // RL4
        end
    end

    // ======================================================================
    // float result fifo: dma side drains; a full fifo drops the sample,
    // since the converter cannot be stalled mid-period
    logic push_pend;
    always_ff @(posedge ref_clk) begin
        if (rst) push_pend <= 1'b0;
        else     push_pend <= state == ASC_DONE;
    end
    asc_fifo #(.WIDTH(32), .DEPTH(`ASC_FIFO_DEPTH)) u_fifo (
        .clk       (ref_clk),
        .rst       (rst),
        .in_data   (to_float(vchan_result[ptr_start[0]])),                 // RL6
        .in_valid  (push_pend),
        .in_ready  (),
        .out_data  (float_result_port),
        .out_valid (float_valid),
        .out_ready (float_ready)                                           // RL7
    );

    // ======================================================================
    // assertions
    property p_irq_after_done; // RL5
        @(posedge ref_clk) disable iff (rst)
        (state == ASC_DONE && ctl_irq) |=> group_three_scan_end_irq;
    endproperty
    a_irq_after_done: assert property (p_irq_after_done) else $error("irq missing"); // RL5
    property p_end_pulse; // RL4
        @(posedge ref_clk) disable iff (rst)
        group_three_end_output |=> !group_three_end_output;
    endproperty
    a_end_pulse: assert property (p_end_pulse) else $error("end not a pulse"); // RL4
    property p_timer_start; // RL1
        @(posedge ref_clk) disable iff (rst)
        (tmr_trig && ctl_timer && state == ASC_IDLE) |=> state == ASC_CONV;
    endproperty
    a_timer_start: assert property (p_timer_start) else $error("timer start lost"); // RL1
    property p_reload; // RL3
        @(posedge ref_clk) disable iff (rst)
        tmr_trig |-> tmr_cnt == timer_period;
    endproperty
    a_reload: assert property (p_reload) else $error("no reload"); // RL3
    property p_sw_start; // RL14
        @(posedge ref_clk) disable iff (rst)
        (sw_start && state == ASC_IDLE) |=> state == ASC_CONV;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("sw start lost"); // RL14
    property p_once; // RL11
        @(posedge ref_clk) disable iff (rst)
        (state == ASC_NEXT && last_vch && group_three_scan_count == 8'h00) |=> state == ASC_DONE;
    endproperty
    a_once: assert property (p_once) else $error("extra scan"); // RL11
    property p_order; // RL12
        @(posedge ref_clk) disable iff (rst)
        (state == ASC_NEXT && !last_vch) |=> vch == $past(vch) + 8'h01;
    endproperty
    a_order: assert property (p_order) else $error("channel order"); // RL12
    property p_result; // RL16
        @(posedge ref_clk) disable iff (rst)
        (conv_end && last_add) |=> vchan_result[$past(vsel)] == $past(acc_sum) + $past(sample_x);
    endproperty
    a_result: assert property (p_result) else $error("result stale"); // RL16
    property p_tick; // RL2
        @(posedge ref_clk) disable iff (rst || !timer_run || !ctl_timer)
        tick |=> !tick ##[1:2] tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick rate"); // RL2
    c_sw_scan: cover property (@(posedge ref_clk) sw_start ##[1:200] group_three_end_output);
    c_timer_scan: cover property (@(posedge ref_clk) tmr_trig ##[1:200] group_three_scan_end_irq);
    c_float_read: cover property (@(posedge ref_clk) rd_float);
endmodule

/* File: bench/asc_dma_model.sv */
`timescale 1ns/100ps
// ==========================================================================
// dma stand-in: single 32 bit reads from one fixed float port
module asc_dma_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic float_valid,
    input  wire logic hold,
    input  wire logic slow,
    output logic      float_ready,
    output logic      block_done
);
    logic [8:0] xfer_cnt; // words moved in the current block
    logic       phase;    // divider for the slow pace
    // ready moves only after an edge, so a pop never straddles a change
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            float_ready <= 1'b0;
            phase       <= 1'b0;
        end else begin
            phase       <= ~phase;
            float_ready <= ~hold & (~slow | phase);
        end
    end
    // 256 words per block, completion pulse, then re-armed at once
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            xfer_cnt   <= 9'h000;
            block_done <= 1'b0;
        end else begin
            block_done <= 1'b0;
            if (float_valid & float_ready) begin
                if (xfer_cnt == 9'h0ff) begin
                    xfer_cnt   <= 9'h000;
                    block_done <= 1'b1;
                end else begin
                    xfer_cnt <= xfer_cnt + 9'h001;
                end
            end
        end
    end
endmodule

/* File: bench/tb_adc_scan_timer_dma_addition.sv */
`timescale 1ns/100ps
`include "asc_defines.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
// ==========================================================================
// bench: apb master, sample source, dma stand-in, float stream monitor
module tb_adc_scan_timer_dma_addition;
    import asc_pkg::*;
    localparam int PER = 30; // short period keeps 256 dma words quick
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [11:0] conv_sample = 12'h000;
    asc_word_t   pwdata = 32'h0, prdata, float_result_port, rd, ew;
    logic        pready, pslverr, er, float_valid, float_ready, irq, end_p, done;
    logic        hold = 1'b0, slow = 1'b0, tmr = 1'b0;
    logic [3:0]  conv_channel;
    int          err_total = 0, n_checks = 0, n_end = 0, n_irq = 0, n_done = 0, b_end, b_irq, s;
    int          seed = 32'h072b1a6c;
    bit          seen1 = 1'b0;
    time         t_last = 0;
    asc_word_t   exp_q[$]; // expected float words, oldest first
    asc_core u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_sample(conv_sample), .conv_channel(conv_channel), .group_three_scan_end_irq(irq),
        .group_three_end_output(end_p), .float_result_port(float_result_port),
        .float_valid(float_valid), .float_ready(float_ready));
    asc_dma_model u_dma (.ref_clk(ref_clk), .rst(rst), .float_valid(float_valid), .hold(hold),
        .slow(slow), .float_ready(float_ready), .block_done(done));
    always #5 ref_clk = ~ref_clk;
    // ==========================================================================
    // helpers
    function automatic asc_word_t to_float(input int v);
        int a;
        int p;
        a = (v < 0) ? -v : v;
        p = 0;
        if (a == 0) return 32'h0;
        while ((a >> (p + 1)) != 0) p++;
        return {v < 0, 8'(127 + p), 23'((a << (23 - p)) & 32'h007fffff)};
    endfunction
    // one apb transfer; held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input asc_word_t d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // bounded wait for the group end pulse
    task automatic wait_end;
        int i;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (end_p !== 1'b1 && i < 400);
        `CHK(end_p, 1'b1)
    endtask
    // one software-started group; same sample on both channels
    task automatic sw_group(input logic [7:0] c, input logic [1:0] add, input bit note);
        int m0;
        int m1;
        int v;
        m0 = n_end;
        m1 = n_irq;
        s = $random(seed) % 2048;
        v = (add == 2'b01) ? 4 * s : s;
        conv_sample <= s[11:0];
        if (note) exp_q.push_back(to_float(v));
        apb(1'b1, `ASC_OFF_CTRL, {24'h0, c});
        apb(1'b1, `ASC_OFF_FORMAT, {30'h0, add});
        apb(1'b1, `ASC_OFF_START, 32'h1);
        wait_end();
        repeat (60) @(posedge ref_clk);
        `CHK(n_end - m0, 1)
        `CHK(n_irq - m1, int'(c[4]))
        apb(1'b0, `ASC_OFF_RES0, 32'h0);
        `CHK(rd[13:0], 14'(v))
        apb(1'b0, `ASC_OFF_RES1, 32'h0);
        `CHK(rd[13:0], 14'(v))
    endtask
    task automatic test_done;
        if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================================================
    // monitor: float words against notes, event pulses and their spacing
    always @(posedge ref_clk) begin
        if (!rst && float_valid === 1'b1 && float_ready === 1'b1) begin
            `CHK(exp_q.size() > 0, 1'b1)
            if (exp_q.size() > 0) begin
                ew = exp_q.pop_front();
                `CHK(float_result_port, ew)
            end
        end
        if (!rst && end_p === 1'b1) begin
            if (tmr && t_last != 0) `CHK(int'(($time - t_last) / 10), PER * `ASC_TICK_NS / `ASC_CLK_NS)
            n_end++;
            t_last = $time;
        end
        if (!rst && irq === 1'b1) begin
            n_irq++;
            `CHK(end_p, 1'b1)
        end
        if (!rst && done === 1'b1) n_done++;
        if (conv_channel === 4'h1) seen1 = 1'b1;
    end
    // watchdog: roughly three times the expected run
    initial begin
        #800000;
        err_total++;
        test_done();
    end
    // ==========================================================================
    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        // reset values, then an unmapped place
        apb(1'b0, `ASC_OFF_TPERIOD, 32'h0);
        `CHK(rd, {16'h0, `ASC_RST_PERIOD})
        apb(1'b0, `ASC_OFF_TIPHASE, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b0, `ASC_OFF_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, 12'h0f0, 32'hffffffff);
        `CHK(er, 1'b1)
        apb(1'b0, 12'h0f0, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        // two channels, software start, with and without addition
        apb(1'b1, `ASC_OFF_PTRS, 32'h0100);
        apb(1'b1, `ASC_OFF_VCFG0, 32'h00002000);
        apb(1'b1, `ASC_OFF_VCFG1, 32'h00002001);
        apb(1'b1, `ASC_OFF_COUNT, 32'h0);
        sw_group(8'h50, 2'b01, 1'b1);
        `CHK(seen1, 1'b1)
        sw_group(8'h50, 2'b00, 1'b1);
        sw_group(8'h40, 2'b01, 1'b1);
        // stalled dma: fifo fills, the surplus is dropped
        hold <= 1'b1;
        for (int k = 0; k < 34; k++) sw_group(8'h50, 2'b01, k < 32);
        `CHK(exp_q.size(), 32)
        `CHK(float_valid, 1'b1)
        hold <= 1'b0;
        repeat (100) @(posedge ref_clk);
        `CHK(exp_q.size(), 0)
        `CHK(float_valid, 1'b0)
        // timer trigger, one channel, new random sample every group
        apb(1'b1, `ASC_OFF_PTRS, 32'h0);
        apb(1'b1, `ASC_OFF_VCFG0, 32'h0);
        apb(1'b1, `ASC_OFF_FORMAT, 32'h0);
        apb(1'b1, `ASC_OFF_TIPHASE, 32'h1);
        apb(1'b1, `ASC_OFF_TPERIOD, PER);
        apb(1'b1, `ASC_OFF_CTRL, 32'h52);
        b_end = n_end;
        b_irq = n_irq;
        s = $random(seed) % 2048;
        conv_sample <= s[11:0];
        exp_q.push_back(to_float(s));
        slow <= 1'b1;
        tmr <= 1'b1;
        t_last = 0;
        apb(1'b1, `ASC_OFF_START, 32'h2);
        for (int k = 0; k < 260; k++) begin
            wait_end();
            if (k < 259) begin
                s = $random(seed) % 2048;
                conv_sample <= s[11:0];
                exp_q.push_back(to_float(s));
            end
        end
        apb(1'b1, `ASC_OFF_START, 32'h0);
        tmr <= 1'b0;
        repeat (100) @(posedge ref_clk);
        `CHK(n_end - b_end, 260)
        `CHK(n_irq - b_irq, 260)
        `CHK(n_done, 1)
        `CHK(exp_q.size(), 0)
        apb(1'b0, `ASC_OFF_RES0, 32'h0);
        `CHK(rd[13:0], 14'(s))
        apb(1'b0, `ASC_OFF_FLOAT, 32'h0);
        `CHK(rd, to_float(s))
        test_done();
    end
endmodule
